// >>> rtl/cpf_pkg.sv
// constants and types shared by the pixel output formatter
package cpf_pkg;

   // ********************************************
   // link constants
   // ********************************************
   localparam int NUM_DATA_LANES = 4;
   localparam int NUM_LANES = 5;
   localparam int NUM_VC = 4;
   localparam int RING_AW = 2;
   localparam logic [1:0] LP_STOP = 2'h3;
   localparam logic [1:0] LP_REQ = 2'h1;
   localparam logic [1:0] LP_BRIDGE = 2'h0;
   localparam logic [7:0] HS_SYNC_BYTE = 8'hb8;
   localparam logic [5:0] DT_FRAME_START = 6'h00;
   localparam logic [5:0] DT_FRAME_END = 6'h01;
   localparam logic [5:0] DT_LINE_START = 6'h02;
   localparam logic [5:0] DT_LINE_END = 6'h03;
   localparam logic [5:0] DT_LONG_MIN = 6'h10;
   localparam logic [1:0] HDR_LAST = 2'h3;
   localparam logic [1:0] CRC_LAST = 2'h1;
   localparam logic [6:0] WORD_BITS = 7'h40;

   // ********************************************
   // types
   // ********************************************
   typedef logic [NUM_LANES-1:0][1:0] cpf_lp_t;
   typedef logic [NUM_DATA_LANES-1:0][7:0] cpf_bytes_t;

   typedef struct packed {
      logic [2:0] laneCount;
      logic [7:0] clockSettleTime;
      logic [7:0] dataSettleTime;
   } cpf_cfg_s;

   typedef enum logic [2:0] {EV_WORD, EV_LSTART, EV_LEND, EV_FSTART, EV_FEND} cpf_ev_e;

   typedef struct packed {
      cpf_ev_e kind;
      logic [1:0] vc;
      logic [5:0] dt;
      logic [3:0] cnt;
      logic [63:0] word;
   } cpf_entry_s;

   typedef struct packed {
      logic ok;
      logic [6:0] bits;
      logic [3:0] ppc;
      logic [12:0] maxPix;
   } cpf_fmt_s;

   typedef enum logic [1:0] {LN_STOP, LN_REQ, LN_SETTLE, LN_HS} cpf_lane_e;
   typedef enum logic [1:0] {PH_HDR, PH_PAY, PH_TAIL} cpf_phase_e;

   // ********************************************
   // pointer helpers
   // ********************************************
   function automatic logic [RING_AW:0] cpf_bin2gray(input logic [RING_AW:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [RING_AW:0] cpf_gray2bin(input logic [RING_AW:0] g);
      logic [RING_AW:0] b;
      b = g;
      for (int k = RING_AW - 1; k >= 0; k--) begin
         b[k] = b[k+1] ^ g[k];
      end
      return b;
   endfunction

endpackage

// >>> rtl/cpf_pixel_formatter.sv
// link-side lane tracking, packet unpacking and pixel-clock word output
`timescale 1ns/1ps

// Behaviour
// R1: output format code changes only while every line sync bit is low.
// R2: type 0x20 gives 48 bits, 4 pixels of 12, at most 2880 per line.
// R3: type 0x21 gives 60 bits, 4 pixels of 15, at most 2880 per line.
// R4: type 0x22 gives 64 bits, 4 pixels of 16, at most 2880 per line.
// R5: type 0x23 gives 54 bits, 3 pixels of 18, at most 2556 per line.
// R6: type 0x24 gives 48 bits, 2 pixels of 24, at most 1920 per line.
// R7: type 0x28 gives 48 bits, 8 pixels of 6, at most 7680 per line.
// R8: type 0x29 gives 56 bits, 8 pixels of 7, at most 6576 per line.
// R9: type 0x2A gives 64 bits, 8 pixels of 8, at most 5760 per line.
// R10: type 0x2B gives 40 bits, 4 pixels of 10, at most 4032 per line.
// R11: type 0x2C gives 48 bits, 4 pixels of 12, at most 3840 per line.
// R12: type 0x2D gives 56 bits, 4 pixels of 14, at most 3288 per line.
// R13: type 0x18 gives 64 bits; odd lines 8 pixels, even lines 4; max 2880.
// R14: type 0x19 gives 40 bits; odd lines 4 pixels, even lines 2; max 2304.
// R15: types 0x1C and 0x1D pack exactly like 0x18 and 0x19.
// R16: type 0x1A gives 48 bits, 4 pixels, at most 3840 per line.
// R17: type 0x1E gives 64 bits, 4 pixels, at most 2880 per line.
// R18: type 0x1F gives 40 bits, 2 pixels, at most 2304 per line.
// R19: types 0x30 to 0x37 give 64 bits, 8 pixels of 8, max 5760.
// R20: every lane is tracked as it toggles between low-power and high-speed.
// R21: sender enters high speed via LP-11, LP-01, LP-00; leaves via LP-11.
// R22: separate clock and data settle intervals pass before high-speed sampling.
// R23: a word per pixel clock, with pixel count giving its valid pixels.
// R24: one line sync bit per virtual channel, high during that line.
// R25: word bits above the valid count are driven to zero.
module cpf_pixel_formatter (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic lnkClk,
   input wire cpf_pkg::cpf_lp_t lpLevel,
   input wire cpf_pkg::cpf_bytes_t hsByte,
   input wire cpf_pkg::cpf_cfg_s linkCfg,
   output logic [63:0] pixelWord,
   output logic [3:0] pixelCount,
   output logic pixelValid,
   output logic [5:0] formatCode,
   output logic [1:0] vcId,
   output logic [3:0] lineSync,
   output logic [3:0] frameSync,
   output logic [4:0] laneHs,
   output logic ringOverflow
);
   import cpf_pkg::*;

   // ********************************************
   // state
   // ********************************************
   typedef struct packed {
      cpf_lp_t lpS1;
      cpf_lp_t lpS2;
      cpf_cfg_s cfgS1;
      cpf_cfg_s cfgS2;
      logic [RING_AW:0] rdG1;
      logic [RING_AW:0] rdG2;
      cpf_lane_e [NUM_LANES-1:0] lane;
      logic [NUM_LANES-1:0][7:0] settleCnt;
      logic [NUM_LANES-1:0] synced;
      logic [NUM_LANES-1:0] hsFlag;
      cpf_phase_e phase;
      logic [1:0] hdrCnt;
      logic [1:0] tailCnt;
      logic [31:0] hdr;
      logic [15:0] byteLeft;
      logic [1:0] curVc;
      logic [5:0] curType;
      logic [127:0] acc;
      logic [7:0] fill;
      logic [12:0] linePix;
      logic [NUM_VC-1:0] evenLine;
      logic pendV;
      cpf_entry_s pend;
      logic [RING_AW:0] wrBin;
      logic [RING_AW:0] wrG;
      cpf_entry_s [(1<<RING_AW)-1:0] ring;
      logic ovf;
   } cpf_lnk_s;

   typedef struct packed {
      logic [RING_AW:0] wrG1;
      logic [RING_AW:0] wrG2;
      logic [RING_AW:0] rdBin;
      logic [RING_AW:0] rdG;
      logic [NUM_LANES-1:0] hsS1;
      logic [NUM_LANES-1:0] hsS2;
      logic ovfS1;
      logic ovfS2;
      logic [63:0] word;
      logic [3:0] cnt;
      logic valid;
      logic [5:0] fmtCode;
      logic [1:0] vc;
      logic [NUM_VC-1:0] lineSync;
      logic [NUM_VC-1:0] frameSync;
   } cpf_pix_s;

   cpf_lnk_s sL, nxt_sL;
   cpf_pix_s sP, nxt_sP;
   logic [1:0] lnkRstSync_ff;
   logic lnkRst;

   // ********************************************
   // format table
   // ********************************************
   function automatic cpf_fmt_s cpf_fmt(input logic [5:0] dt, input logic even);
      cpf_fmt_s f;
      f = '0;
      f.ok = 1'b1;
      unique casez (dt)
         6'h20: f = '{1'b1, 7'h30, 4'h4, 13'hb40}; // R2
         6'h21: f = '{1'b1, 7'h3c, 4'h4, 13'hb40}; // R3
         6'h22: f = '{1'b1, 7'h40, 4'h4, 13'hb40}; // R4
         6'h23: f = '{1'b1, 7'h36, 4'h3, 13'h9fc}; // R5
         6'h24: f = '{1'b1, 7'h30, 4'h2, 13'h780}; // R6
         6'h28: f = '{1'b1, 7'h30, 4'h8, 13'h1e00}; // R7
         6'h29: f = '{1'b1, 7'h38, 4'h8, 13'h19b0}; // R8
         6'h2a: f = '{1'b1, 7'h40, 4'h8, 13'h1680}; // R9
         6'h2b: f = '{1'b1, 7'h28, 4'h4, 13'hfc0}; // R10
         6'h2c: f = '{1'b1, 7'h30, 4'h4, 13'hf00}; // R11
         6'h2d: f = '{1'b1, 7'h38, 4'h4, 13'hcd8}; // R12
         // 0x1c/0x1d share the 0x18/0x19 entries
         6'h18, 6'h1c: f = '{1'b1, 7'h40, even ? 4'h4 : 4'h8, 13'hb40}; // R13 R15
         6'h19, 6'h1d: f = '{1'b1, 7'h28, even ? 4'h2 : 4'h4, 13'h900}; // R14 R15
         6'h1a: f = '{1'b1, 7'h30, 4'h4, 13'hf00}; // R16
         6'h1e: f = '{1'b1, 7'h40, 4'h4, 13'hb40}; // R17
         6'h1f: f = '{1'b1, 7'h28, 4'h2, 13'h900}; // R18
         6'b110???: f = '{1'b1, 7'h40, 4'h8, 13'h1680}; // R19
         default: f = '0;
      endcase
      return f;
   endfunction

   function automatic logic [63:0] cpf_mask(input logic [6:0] bits);
      if (bits >= WORD_BITS) begin
         return '1;
      end
      return (64'h1 << bits) - 64'h1;
   endfunction

   // ********************************************
   // link reset synchroniser
   // ********************************************
   always_ff @(posedge lnkClk) begin
      lnkRstSync_ff <= {lnkRstSync_ff[0], rst};
   end
   assign lnkRst = lnkRstSync_ff[1];

   // ********************************************
   // link domain
   // ********************************************
   always_comb begin
      cpf_fmt_s fmt;
      cpf_entry_s ent;
      logic [RING_AW:0] rdBinL;
      logic full;
      logic burst;
      logic newPend;
      logic doPush;
      logic [7:0] settle;
      logic [7:0] b;
      logic [31:0] hdrW;
      fmt = '0;
      ent = '0;
      rdBinL = '0;
      full = 1'b0;
      burst = 1'b0;
      newPend = 1'b0;
      doPush = 1'b0;
      settle = '0;
      b = '0;
      hdrW = '0;
      nxt_sL = sL;
      nxt_sL.lpS1 = lpLevel;
      nxt_sL.lpS2 = sL.lpS1;
      nxt_sL.cfgS1 = linkCfg;
      nxt_sL.cfgS2 = sL.cfgS1;
      nxt_sL.rdG1 = sP.rdG;
      nxt_sL.rdG2 = sL.rdG1;

      // lane 0 is the clock lane, lanes 1..4 carry data
      for (int i = 0; i < NUM_LANES; i++) begin
         settle = (i == 0) ? sL.cfgS2.clockSettleTime : sL.cfgS2.dataSettleTime; // R22
         unique case (sL.lane[i])
            LN_STOP: begin
               if (sL.lpS2[i] == LP_REQ) begin
                  nxt_sL.lane[i] = LN_REQ; // R21
               end
            end
            LN_REQ: begin
               if (sL.lpS2[i] == LP_BRIDGE) begin
                  nxt_sL.lane[i] = LN_SETTLE; // R21
                  nxt_sL.settleCnt[i] = '0;
               end else if (sL.lpS2[i] != LP_REQ) begin
                  nxt_sL.lane[i] = LN_STOP;
               end
            end
            LN_SETTLE: begin
               if (sL.lpS2[i] == LP_STOP) begin
                  nxt_sL.lane[i] = LN_STOP;
               end else if (sL.settleCnt[i] >= settle) begin
                  nxt_sL.lane[i] = LN_HS; // R22
               end else begin
                  nxt_sL.settleCnt[i] = sL.settleCnt[i] + 8'h1;
               end
            end
            LN_HS: begin
               if (sL.lpS2[i] == LP_STOP) begin
                  nxt_sL.lane[i] = LN_STOP; // R20 R21
               end
            end
         endcase
         nxt_sL.hsFlag[i] = (nxt_sL.lane[i] == LN_HS); // R20
         if (nxt_sL.lane[i] != LN_HS) begin
            nxt_sL.synced[i] = 1'b0;
         end else if (i > 0 && sL.lane[i] == LN_HS && hsByte[i-1] == HS_SYNC_BYTE) begin
            nxt_sL.synced[i] = 1'b1;
         end
      end

      // bytes count only once every lane in use is synced behind the clock lane
      burst = sL.hsFlag[0];
      for (int i = 1; i < NUM_LANES; i++) begin
         if (3'(i) <= sL.cfgS2.laneCount && !sL.synced[i]) begin
            burst = 1'b0;
         end
      end

      if (!burst) begin
         nxt_sL.phase = PH_HDR;
         nxt_sL.hdrCnt = '0;
      end else begin
         for (int j = 0; j < NUM_DATA_LANES; j++) begin
            if (3'(j) < sL.cfgS2.laneCount) begin
               b = hsByte[j];
               unique case (nxt_sL.phase)
                  PH_HDR: begin
                     hdrW = {b, nxt_sL.hdr[31:8]};
                     nxt_sL.hdr = hdrW;
                     if (nxt_sL.hdrCnt == HDR_LAST) begin
                        if (hdrW[5:0] < DT_LONG_MIN) begin
                           if (hdrW[5:0] <= DT_LINE_END) begin
                              newPend = 1'b1;
                              nxt_sL.pend = '0;
                              nxt_sL.pend.vc = hdrW[7:6];
                              nxt_sL.pend.dt = hdrW[5:0];
                              unique case (hdrW[5:0])
                                 DT_FRAME_START: nxt_sL.pend.kind = EV_FSTART;
                                 DT_FRAME_END: nxt_sL.pend.kind = EV_FEND;
                                 DT_LINE_START: nxt_sL.pend.kind = EV_LSTART;
                                 default: nxt_sL.pend.kind = EV_LEND;
                              endcase
                              if (hdrW[5:0] == DT_FRAME_START) begin
                                 nxt_sL.evenLine[hdrW[7:6]] = 1'b0;
                              end
                           end
                        end else begin
                           nxt_sL.curVc = hdrW[7:6];
                           nxt_sL.curType = hdrW[5:0];
                           nxt_sL.byteLeft = hdrW[23:8];
                           nxt_sL.linePix = '0;
                           nxt_sL.acc = '0;
                           nxt_sL.fill = '0;
                           nxt_sL.tailCnt = '0;
                           nxt_sL.phase = (hdrW[23:8] == 16'h0) ? PH_TAIL : PH_PAY;
                        end
                     end
                     nxt_sL.hdrCnt = nxt_sL.hdrCnt + 2'h1;
                  end
                  PH_PAY: begin
                     nxt_sL.acc = nxt_sL.acc | (128'(b) << nxt_sL.fill);
                     nxt_sL.fill = nxt_sL.fill + 8'h8;
                     nxt_sL.byteLeft = nxt_sL.byteLeft - 16'h1;
                     if (nxt_sL.byteLeft == 16'h0) begin
                        nxt_sL.phase = PH_TAIL;
                        nxt_sL.evenLine[nxt_sL.curVc] = ~nxt_sL.evenLine[nxt_sL.curVc];
                     end
                  end
                  PH_TAIL: begin
                     if (nxt_sL.tailCnt == CRC_LAST) begin
                        nxt_sL.phase = PH_HDR;
                        nxt_sL.hdrCnt = '0;
                     end
                     nxt_sL.tailCnt = nxt_sL.tailCnt + 2'h1;
                  end
                  default: nxt_sL.phase = PH_HDR;
               endcase
            end
         end
      end

      // one ring write per cycle; a finished word goes before a sync event
      rdBinL = cpf_gray2bin(sL.rdG2);
      full = (sL.wrBin[RING_AW] != rdBinL[RING_AW]) &&
             (sL.wrBin[RING_AW-1:0] == rdBinL[RING_AW-1:0]);
      fmt = cpf_fmt(sL.curType, sL.evenLine[sL.curVc]);
      if (fmt.ok && nxt_sL.fill >= {1'b0, fmt.bits}) begin
         ent.kind = EV_WORD;
         ent.vc = sL.curVc;
         ent.dt = sL.curType;
         ent.cnt = fmt.ppc; // R23
         ent.word = nxt_sL.acc[63:0] & cpf_mask(fmt.bits); // R25
         nxt_sL.acc = nxt_sL.acc >> fmt.bits;
         nxt_sL.fill = nxt_sL.fill - {1'b0, fmt.bits};
         if (sL.linePix < fmt.maxPix) begin
            doPush = 1'b1; // R2 R3 R4 R5 R6 R7 R8 R9 R10 R11 R12 R13 R14 R16 R17 R18 R19
            nxt_sL.linePix = sL.linePix + 13'(fmt.ppc);
         end
      end else if (sL.pendV) begin
         ent = sL.pend;
         doPush = 1'b1;
         if (!newPend) begin
            nxt_sL.pendV = 1'b0;
         end
      end
      if (newPend) begin
         nxt_sL.pendV = 1'b1;
      end
      if (doPush) begin
         if (full) begin
            nxt_sL.ovf = 1'b1;
         end else begin
            nxt_sL.ring[sL.wrBin[RING_AW-1:0]] = ent;
            nxt_sL.wrBin = sL.wrBin + 3'h1;
         end
      end
      nxt_sL.wrG = cpf_bin2gray(nxt_sL.wrBin);
   end

   always_ff @(posedge lnkClk) begin
      if (lnkRst) begin
         sL <= '0;
      end else begin
         sL <= nxt_sL;
      end
   end

   // ********************************************
   // pixel domain
   // ********************************************
   always_comb begin
      cpf_entry_s e;
      e = sL.ring[sP.rdBin[RING_AW-1:0]];
      nxt_sP = sP;
      nxt_sP.wrG1 = sL.wrG;
      nxt_sP.wrG2 = sP.wrG1;
      nxt_sP.hsS1 = sL.hsFlag; // R20
      nxt_sP.hsS2 = sP.hsS1;
      nxt_sP.ovfS1 = sL.ovf;
      nxt_sP.ovfS2 = sP.ovfS1;
      nxt_sP.valid = 1'b0;
      nxt_sP.cnt = '0;
      if (cpf_gray2bin(sP.wrG2) != sP.rdBin) begin
         nxt_sP.rdBin = sP.rdBin + 3'h1;
         unique case (e.kind)
            EV_WORD: begin
               if (sP.lineSync == '0) begin
                  nxt_sP.fmtCode = e.dt; // R1
                  nxt_sP.vc = e.vc;
               end
               // words of another type inside a line are dropped
               if (sP.lineSync == '0 || (e.dt == sP.fmtCode && e.vc == sP.vc)) begin
                  nxt_sP.word = e.word; // R23
                  nxt_sP.cnt = e.cnt; // R23
                  nxt_sP.valid = 1'b1;
               end
            end
            EV_LSTART: nxt_sP.lineSync[e.vc] = 1'b1; // R24
            EV_LEND: nxt_sP.lineSync[e.vc] = 1'b0; // R24
            EV_FSTART: nxt_sP.frameSync[e.vc] = 1'b1;
            EV_FEND: nxt_sP.frameSync[e.vc] = 1'b0;
            default: nxt_sP.valid = 1'b0;
         endcase
      end
      nxt_sP.rdG = cpf_bin2gray(nxt_sP.rdBin);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sP <= '0;
      end else begin
         sP <= nxt_sP;
      end
   end

   // ********************************************
   // outputs
   // ********************************************
   assign pixelWord = sP.word;
   assign pixelCount = sP.cnt;
   assign pixelValid = sP.valid;
   assign formatCode = sP.fmtCode;
   assign vcId = sP.vc;
   assign lineSync = sP.lineSync;
   assign frameSync = sP.frameSync;
   assign laneHs = sP.hsS2;
   assign ringOverflow = sP.ovfS2;

endmodule

// >>> test/cpf_assertions.sv
// port checker for the pixel output formatter, bound to its top module
`timescale 1ns/1ps
module cpf_assertions (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic lnkClk,
   input wire cpf_pkg::cpf_lp_t lpLevel,
   input wire cpf_pkg::cpf_bytes_t hsByte,
   input wire cpf_pkg::cpf_cfg_s linkCfg,
   input wire logic [63:0] pixelWord,
   input wire logic [3:0] pixelCount,
   input wire logic pixelValid,
   input wire logic [5:0] formatCode,
   input wire logic [1:0] vcId,
   input wire logic [3:0] lineSync,
   input wire logic [3:0] frameSync,
   input wire logic [4:0] laneHs,
   input wire logic ringOverflow
);
   import cpf_pkg::*;
   // ****
   // word bits and odd-line pixels per word by type
   // ****
   function automatic logic [10:0] fmtOf(input logic [5:0] c);
      case (c)
         6'h20, 6'h2c, 6'h1a: return {7'h30, 4'h4};
         6'h21: return {7'h3c, 4'h4};
         6'h22, 6'h1e: return {7'h40, 4'h4};
         6'h23: return {7'h36, 4'h3};
         6'h24: return {7'h30, 4'h2};
         6'h28: return {7'h30, 4'h8};
         6'h29: return {7'h38, 4'h8};
         6'h2b, 6'h19, 6'h1d: return {7'h28, 4'h4};
         6'h2d: return {7'h38, 4'h4};
         6'h1f: return {7'h28, 4'h2};
         default: return {7'h40, 4'h8};
      endcase
   endfunction
   logic [10:0] fmt;
   logic yuv;
   assign fmt = fmtOf(formatCode);
   assign yuv = formatCode inside {6'h18, 6'h19, 6'h1c, 6'h1d};
   // ****
   // properties
   // ****
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_link_idle;
      (lpLevel == {NUM_LANES{LP_STOP}}) [*5];
   endsequence
   sequence s_word_out;
      pixelValid ##0 (lineSync != 4'h0);
   endsequence
   a_code_hold_sync: assert property ($changed(formatCode) |-> $past(lineSync) == 4'h0)
      else $error("format code changed inside a line");
   a_vc_hold_sync: assert property ($changed(vcId) |-> $past(lineSync) == 4'h0)
      else $error("channel changed inside a line");
   a_word_upper_zero: assert property (pixelValid |-> (pixelWord >> fmt[10:4]) == 64'h0)
      else $error("bits above word width not zero");
   a_count_by_code: assert property (pixelValid |-> pixelCount == fmt[3:0] ||
      (yuv && pixelCount == {1'b0, fmt[3:1]})) else $error("pixel count wrong for type");
   a_count_idle_zero: assert property (!pixelValid |-> pixelCount == 4'h0)
      else $error("pixel count without word");
   a_word_stands: assert property (!pixelValid |=> $stable(pixelWord) || pixelValid)
      else $error("word changed without valid");
   a_sync_line_word: assert property (s_word_out |-> lineSync[vcId])
      else $error("word inside other channel line");
   a_lane_hs_drop: assert property (s_link_idle |-> laneHs == 5'h00)
      else $error("lane high speed while stopped");
   a_reset_clears: assert property (disable iff (1'b0) rst |=> pixelValid == 1'b0 &&
      pixelWord == 64'h0 && lineSync == 4'h0 && frameSync == 4'h0 && formatCode == 6'h0)
      else $error("outputs not cleared by reset");
endmodule
bind cpf_pixel_formatter cpf_assertions u_cpf_assertions (
   .sys_clk(sys_clk), .rst(rst), .lnkClk(lnkClk), .lpLevel(lpLevel), .hsByte(hsByte),
   .linkCfg(linkCfg), .pixelWord(pixelWord), .pixelCount(pixelCount), .pixelValid(pixelValid),
   .formatCode(formatCode), .vcId(vcId), .lineSync(lineSync), .frameSync(frameSync),
   .laneHs(laneHs), .ringOverflow(ringOverflow)
);

// >>> test/cpf_link_model.sv
// behavioural sensor-side link sender: lane levels and high-speed bytes
`timescale 1ns/1ps
module cpf_link_model (
   input wire logic lnkClk,
   input wire logic [2:0] nLane,
   output cpf_pkg::cpf_lp_t lpLevel,
   output cpf_pkg::cpf_bytes_t hsByte
);
   import cpf_pkg::*;
   logic [7:0] q [$];
   logic [7:0] fill = 8'h07;
   logic busy = 1'b0;
   initial lpLevel = {NUM_LANES{LP_STOP}};
   initial hsByte = {NUM_DATA_LANES{8'h07}};
   // filler decodes as ignored short headers and changes every cycle
   always @(posedge lnkClk) begin
      fill <= fill ^ 8'h0b;
      if (!busy) hsByte <= {NUM_DATA_LANES{fill}};
   end
   task automatic step(input logic [1:0] lv, input int n);
      repeat (n) begin
         lpLevel <= {NUM_LANES{lv}};
         hsByte <= {NUM_DATA_LANES{fill}};
         @(posedge lnkClk);
      end
   endtask
   task automatic burst();
      busy = 1'b1;
      @(posedge lnkClk);
      step(LP_REQ, 4);
      step(LP_BRIDGE, 30);
      hsByte <= {NUM_DATA_LANES{HS_SYNC_BYTE}};
      @(posedge lnkClk);
      while (q.size() > 0) begin
         for (int j = 0; j < NUM_DATA_LANES; j++) begin
            hsByte[j] <= (j < nLane && q.size() > 0) ? q.pop_front() : fill;
         end
         @(posedge lnkClk);
      end
      step(LP_STOP, 4);
      busy = 1'b0;
   endtask
   task automatic blip(input int n, input bit skip);
      busy = 1'b1;
      @(posedge lnkClk);
      if (!skip) step(LP_REQ, 4);
      step(LP_BRIDGE, n);
      step(LP_STOP, 4);
      busy = 1'b0;
   endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the pixel output formatter
`timescale 1ns/1ps
module testbench;
   import cpf_pkg::*;
   logic sys_clk;
   logic lnkClk;
   logic rst = 1'b1;
   cpf_lp_t lpLevel;
   cpf_bytes_t hsByte;
   cpf_cfg_s linkCfg = {3'h1, 8'h02, 8'h14};
   logic [63:0] pixelWord;
   logic [3:0] pixelCount, lineSync, frameSync;
   logic pixelValid, ringOverflow;
   logic [5:0] formatCode;
   logic [1:0] vcId;
   logic [4:0] laneHs;
   logic [4:0] hsSeen = 5'h00;
   logic hsClr = 1'b0;
   logic [79:0] got [$];
   logic [79:0] exp [$];
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   // rows: type code, word bits, pixels per word on an odd line
   logic [16:0] tbl [18] = '{{6'h20, 7'h30, 4'h4}, {6'h21, 7'h3c, 4'h4}, {6'h22, 7'h40, 4'h4},
      {6'h23, 7'h36, 4'h3}, {6'h24, 7'h30, 4'h2}, {6'h28, 7'h30, 4'h8}, {6'h29, 7'h38, 4'h8},
      {6'h2a, 7'h40, 4'h8}, {6'h2b, 7'h28, 4'h4}, {6'h2c, 7'h30, 4'h4}, {6'h2d, 7'h38, 4'h4},
      {6'h18, 7'h40, 4'h8}, {6'h19, 7'h28, 4'h4}, {6'h1c, 7'h40, 4'h8}, {6'h1d, 7'h28, 4'h4},
      {6'h1a, 7'h30, 4'h4}, {6'h1e, 7'h40, 4'h4}, {6'h1f, 7'h28, 4'h2}};
   cpf_pixel_formatter u_cpf_pixel_formatter (
      .sys_clk(sys_clk), .rst(rst), .lnkClk(lnkClk), .lpLevel(lpLevel), .hsByte(hsByte),
      .linkCfg(linkCfg), .pixelWord(pixelWord), .pixelCount(pixelCount),
      .pixelValid(pixelValid), .formatCode(formatCode), .vcId(vcId), .lineSync(lineSync),
      .frameSync(frameSync), .laneHs(laneHs), .ringOverflow(ringOverflow));
   cpf_link_model u_cpf_link_model (
      .lnkClk(lnkClk), .nLane(linkCfg.laneCount), .lpLevel(lpLevel), .hsByte(hsByte));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      lnkClk = 1'b0;
      #0.5;
      forever #6 lnkClk = ~lnkClk;
   end
   // ****
   // monitor and timeout
   // ****
   always @(posedge sys_clk) begin
      if (pixelValid === 1'b1) got.push_back({pixelWord, pixelCount, formatCode, vcId, lineSync});
      hsSeen <= hsClr ? 5'h00 : (hsSeen | laneHs);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [79:0] g, input logic [79:0] e);
      total_checks++;
      if (g !== e) begin
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
         n_fail++;
      end
   endtask
   // short packet when dt is below 0x10; pc zero on a long one means dropped
   task automatic pkt(input logic [1:0] vc, input logic [5:0] dt, input logic [6:0] nb,
                      input logic [3:0] pc, input logic [3:0] ls);
      logic [127:0] p;
      u_cpf_link_model.q.push_back({vc, dt});
      u_cpf_link_model.q.push_back(dt < 6'h10 ? 8'h00 : 8'h10);
      u_cpf_link_model.q.push_back(8'h00);
      u_cpf_link_model.q.push_back(8'h00);
      if (dt >= 6'h10) begin
         for (int k = 0; k < 16; k++) begin
            p[8*k+:8] = 8'(k * 29 + dt);
            u_cpf_link_model.q.push_back(p[8*k+:8]);
         end
         u_cpf_link_model.q.push_back(8'h00);
         u_cpf_link_model.q.push_back(8'h00);
         for (int i = 0; pc != 4'h0 && i < 128 / nb; i++) begin
            exp.push_back({64'((p >> (i * nb)) & ((128'h1 << nb) - 128'h1)), pc, dt, vc, ls});
         end
      end
   endtask
   task automatic run();
      u_cpf_link_model.burst();
      for (int w = 0; w < 300 && got.size() < exp.size(); w++) @(posedge sys_clk);
      repeat (10) @(posedge sys_clk);
      chk(80'(got.size()), 80'(exp.size()));
      while (got.size() > 0 && exp.size() > 0) chk(got.pop_front(), exp.pop_front());
      got.delete();
      exp.delete();
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      logic [16:0] r;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < 26; i++) begin
         r = i < 18 ? tbl[i] : {6'h30 + 6'(i - 18), 7'h40, 4'h8};
         pkt(i[1:0], DT_FRAME_START, 7'h0, 4'h0, 4'h0);
         pkt(i[1:0], r[16:11], r[10:4], r[3:0], 4'h0);
         pkt(i[1:0], DT_FRAME_END, 7'h0, 4'h0, 4'h0);
         hsClr <= 1'b1;
         @(posedge sys_clk) hsClr <= 1'b0;
         run();
         chk(80'(hsSeen), 80'h1f);
      end
      pkt(2'h1, 6'h2a, 7'h40, 4'h8, 4'h0);
      pkt(2'h1, DT_LINE_START, 7'h0, 4'h0, 4'h0);
      pkt(2'h1, 6'h2a, 7'h40, 4'h8, 4'h2);
      pkt(2'h1, 6'h22, 7'h40, 4'h0, 4'h2);
      pkt(2'h1, DT_LINE_END, 7'h0, 4'h0, 4'h0);
      pkt(2'h1, 6'h22, 7'h40, 4'h4, 4'h0);
      run();
      pkt(2'h0, DT_FRAME_START, 7'h0, 4'h0, 4'h0);
      pkt(2'h0, 6'h1c, 7'h40, 4'h8, 4'h0);
      pkt(2'h0, 6'h1c, 7'h40, 4'h4, 4'h0);
      pkt(2'h0, 6'h19, 7'h28, 4'h4, 4'h0);
      pkt(2'h0, 6'h1d, 7'h28, 4'h2, 4'h0);
      run();
      chk(80'(frameSync), 80'h1);
      hsClr <= 1'b1;
      @(posedge sys_clk) hsClr <= 1'b0;
      u_cpf_link_model.blip(12, 1'b0);
      repeat (10) @(posedge sys_clk);
      chk(80'(hsSeen), 80'h01);
      hsClr <= 1'b1;
      @(posedge sys_clk) hsClr <= 1'b0;
      u_cpf_link_model.blip(40, 1'b1);
      repeat (10) @(posedge sys_clk);
      chk(80'(hsSeen), 80'h00);
      linkCfg <= {3'h4, 8'h02, 8'h14};
      repeat (4) @(posedge sys_clk);
      for (int k = 0; k < 12; k++) pkt(2'h0, 6'(2 + k % 2), 7'h0, 4'h0, 4'h0);
      u_cpf_link_model.burst();
      repeat (40) @(posedge sys_clk);
      chk(80'(ringOverflow), 80'h1);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk({ringOverflow, pixelValid, lineSync, frameSync, formatCode, pixelWord}, 80'h0);
      results();
   end
endmodule
